/* bench/front_end_model.sv */
`timescale 1ns/1ps
module front_end_model (
  // Clock and phase.
  input wire logic clk_sys,
  input wire logic shunt_conv_active,
  // Values handed out in turn.
  input wire logic [15:0] value_a,
  input wire logic [15:0] value_b,
  output logic [15:0] shunt_sample
);
  logic pick_b = 1'b0;
  logic was_active = 1'b0;
  // The value swaps the cycle after shunt_conv_active falls, so samples alternate only when a bus phase or idle gap separates them.
  always @(posedge clk_sys) begin
    was_active <= shunt_conv_active;
    if (was_active && !shunt_conv_active) pick_b <= !pick_b;
  end
  assign shunt_sample = pick_b ? value_b : value_a;
endmodule : front_end_model

/* bench/measure_control_monitor.sv */
`timescale 1ns/1ps
module measure_control_monitor
  import monitor_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // Command port.
  input wire logic cmd_strobe,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic setup_write_busy,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic cmd_reject,
  // Converter and alert.
  input wire logic shunt_conv_active,
  input wire logic bus_conv_active,
  input wire logic conv_ready,
  input wire logic [7:0] vendor_status_flags,
  input wire logic [7:0] comm_fault_status,
  input wire logic alert_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic known = cmd_code inside {CMD_ADC_SETUP, CMD_SHUNT_READING, CMD_ALERT_MASK};
  wire logic go = clk_en && cmd_strobe;
  wire logic rd_go = go && !cmd_write;
  a_read_answer: assert property (rd_go && known |=> rd_valid && !cmd_reject)
    else $error("read not answered");
  a_refused_cmd: assert property (go && (!known || (cmd_write && cmd_code == CMD_SHUNT_READING))
    |=> cmd_reject && !rd_valid) else $error("bad command not refused");
  a_setup_fixed: assert property (rd_go && cmd_code == CMD_ADC_SETUP
    |=> rd_data[15:12] == SETUP_FIXED_BITS) else $error("setup top bits wrong");
  a_mask_high: assert property (rd_go && cmd_code == CMD_ALERT_MASK
    |=> rd_data[15:8] == 8'h00) else $error("mask high byte not zero");
  a_write_silent: assert property (go && cmd_write && cmd_code == CMD_ADC_SETUP
    |=> !rd_valid && !cmd_reject) else $error("setup write answered");
  a_busy_halts: assert property (clk_en && setup_write_busy
    |=> !shunt_conv_active && !bus_conv_active) else $error("conversion not halted");
  a_one_phase: assert property (!(shunt_conv_active && bus_conv_active))
    else $error("both phases active");
  a_alert_quiet: assert property (clk_en && vendor_status_flags == 8'h00
    && comm_fault_status == 8'h00 |=> !alert_active) else $error("alert without cause");
  a_ready_pulse: assert property (clk_en && conv_ready |=> !conv_ready)
    else $error("ready longer than a cycle");
  a_ready_after_phase: assert property ($rose(conv_ready)
    |-> $past(shunt_conv_active || bus_conv_active)) else $error("ready without a conversion");
  a_halt_no_ready: assert property (clk_en && setup_write_busy |=> !conv_ready)
    else $error("ready during setup write");
  c_ready: cover property (conv_ready);
  c_reject: cover property (cmd_reject);
  c_alert: cover property ($rose(alert_active));
endmodule : measure_control_monitor

/* bench/measure_control_tb.sv */
`timescale 1ns/1ps
module measure_control_tb
  import monitor_pkg::*;
;
  logic clk_sys, resetn, clk_en, cmd_strobe, cmd_write, busy, rd_valid, cmd_reject;
  logic sh_act, bus_act, conv_ready, alert_active, seen_s, seen_b;
  logic [7:0] cmd_code, flags, comm;
  logic [15:0] cmd_wdata, rd_data, shunt_sample, va, vb, d;
  int bad_count, checks_done, k, i;
  measure_control #(.CONV_CYC('{4, 5, 6, 7, 8, 9, 10, 11})) uut (.clk_sys(clk_sys),
    .resetn(resetn), .clk_en(clk_en), .cmd_strobe(cmd_strobe), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .setup_write_busy(busy), .rd_data(rd_data),
    .rd_valid(rd_valid), .cmd_reject(cmd_reject), .shunt_sample(shunt_sample),
    .shunt_conv_active(sh_act), .bus_conv_active(bus_act), .conv_ready(conv_ready),
    .vendor_status_flags(flags), .comm_fault_status(comm), .alert_active(alert_active));
  front_end_model fe (.clk_sys(clk_sys), .shunt_conv_active(sh_act), .value_a(va),
    .value_b(vb), .shunt_sample(shunt_sample));
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task cmd(input logic w, input logic [7:0] c, input logic [15:0] wd);
    @(negedge clk_sys);
    busy = w && c == CMD_ADC_SETUP;
    cmd_strobe = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = wd;
    @(negedge clk_sys);
    cmd_strobe = 1'b0;
    busy = 1'b0;
  endtask : cmd
  task rd(input logic [7:0] c, input logic [15:0] exp);
    cmd(1'b0, c, 16'h0000);
    check({15'h0000, rd_valid}, 16'h0001);
    check(rd_data, exp);
  endtask : rd
  task watch(input int n);
    k = 0;
    seen_s = 1'b0;
    seen_b = 1'b0;
    repeat (n) begin
      @(negedge clk_sys);
      k += int'(conv_ready);
      seen_s |= sh_act;
      seen_b |= bus_act;
    end
  endtask : watch
  function automatic logic [15:0] mean2(input logic [15:0] a, input logic [15:0] b);
    logic signed [16:0] s;
    s = $signed({a[15], a}) + $signed({b[15], b});
    return s[16:1];
  endfunction : mean2
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #500000;
    bad_count++;
    finish_test;
  end
  initial begin
    {resetn, cmd_strobe, cmd_write, busy, cmd_code, cmd_wdata, flags, comm} = '0;
    clk_en = 1'b1;
    va = 16'h0000;
    vb = 16'h0000;
    void'($urandom(21660));
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    rd(CMD_ADC_SETUP, ADC_SETUP_RESET);
    rd(CMD_SHUNT_READING, SHUNT_READING_RESET);
    rd(CMD_ALERT_MASK, {8'h00, ALERT_MASK_RESET});
    $display("test reset values done");
    for (i = 0; i < 6; i++) begin
      d = 16'($urandom);
      cmd(1'b1, CMD_ALERT_MASK, d);
      rd(CMD_ALERT_MASK, {8'h00, d[7:0]});
      cmd(1'b1, CMD_ADC_SETUP, d);
      rd(CMD_ADC_SETUP, {SETUP_FIXED_BITS, d[11:0]});
      rd(CMD_ADC_SETUP, {SETUP_FIXED_BITS, d[11:0]});
    end
    cmd(1'b1, CMD_SHUNT_READING, 16'h1234);
    check({15'h0000, cmd_reject}, 16'h0001);
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      cmd(1'b1, CMD_ADC_SETUP, {13'h0000, 3'(i)});
      watch(60);
      check({14'h0000, seen_s, seen_b}, {14'h0000, i[0], i[1]});
      check(16'((k > 1) ? 2 : k), 16'((i[1:0] == 2'b00) ? 0 : (i[2] ? 2 : 1)));
    end
    $display("test modes done");
    for (i = 0; i < 4; i++) begin
      d = 16'($urandom);
      va = {{2{d[13]}}, d[13:0]};
      vb = va + {10'h000, d[15:14], d[2:0], 1'b0};
      cmd(1'b1, CMD_ADC_SETUP, {4'h0, 3'(1 + i % 2), 6'h00, 3'b111});
      for (k = 0; k < 3000 && conv_ready !== 1'b1; k++) @(negedge clk_sys);
      if (k == 3000) begin
        bad_count++;
        finish_test;
      end
      repeat (2) @(negedge clk_sys);
      rd(CMD_SHUNT_READING, mean2(va, vb));
    end
    $display("test averaging done");
    for (i = 0; i < 8; i++) begin
      flags = (i == 4) ? 8'h00 : 8'(1 << i);
      comm = (i == 4) ? 8'(1 << ($urandom % 8)) : 8'h00;
      cmd(1'b1, CMD_ALERT_MASK, 16'(~(1 << i)));
      repeat (2) @(negedge clk_sys);
      check({15'h0000, alert_active}, 16'h0001);
      cmd(1'b1, CMD_ALERT_MASK, 16'(1 << i));
      repeat (2) @(negedge clk_sys);
      check({15'h0000, alert_active}, 16'h0000);
    end
    flags = 8'h10;
    comm = 8'h00;
    cmd(1'b1, CMD_ALERT_MASK, 16'h0000);
    repeat (2) @(negedge clk_sys);
    check({15'h0000, alert_active}, 16'h0000);
    $display("test alert done");
    cmd(1'b1, CMD_ADC_SETUP, 16'h0000);
    clk_en = 1'b0;
    cmd(1'b0, CMD_ADC_SETUP, 16'h0000);
    check({15'h0000, rd_valid}, 16'h0000);
    clk_en = 1'b1;
    flags = 8'h80;
    cmd(1'b1, CMD_ALERT_MASK, 16'h0000);
    cmd(1'b1, CMD_ADC_SETUP, 16'h0ABC);
    check({15'h0000, alert_active}, 16'h0001);
    resetn = 1'b0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    rd(CMD_SHUNT_READING, SHUNT_READING_RESET);
    rd(CMD_ADC_SETUP, ADC_SETUP_RESET);
    check({15'h0000, alert_active}, 16'h0000);
    $display("test clock enable and reset done");
    finish_test;
  end
endmodule : measure_control_tb
bind measure_control measure_control_monitor mon (.clk_sys(clk_sys), .resetn(resetn),
  .clk_en(clk_en), .cmd_strobe(cmd_strobe), .cmd_write(cmd_write), .cmd_code(cmd_code),
  .setup_write_busy(setup_write_busy), .rd_data(rd_data), .rd_valid(rd_valid),
  .cmd_reject(cmd_reject), .shunt_conv_active(shunt_conv_active),
  .bus_conv_active(bus_conv_active), .conv_ready(conv_ready),
  .vendor_status_flags(vendor_status_flags), .comm_fault_status(comm_fault_status),
  .alert_active(alert_active));

/* hw/measure_control.sv */
// Contract
// - Reading adc_setup never alters the settings or disturbs a running conversion.
// - Writing adc_setup halts conversion until the write completes, then restarts with new settings.
// - Bits 11:9 pick 1, 4, 16, 64, 128, 256, 512 or 1024 averaged samples, default 000.
// - Bits 8:6 pick the bus conversion time from 140 us to 8.244 ms, default 100.
// - Bits 5:3 pick the shunt conversion time with the same steps, default 100.
// - Bits 2:0 pick power-down, triggered or continuous shunt, bus or both, default 111.
// - adc_setup resets to 0x4127 and bits 15:12 always read 0100 and ignore writes.
// - shunt_voltage_reading is a 16-bit two's-complement value that resets to zero.
// - With averaging above one, shunt_voltage_reading shows the averaged result.
// - One code step of the shunt reading is 2.5 uV so 81.92 mV reads as 7FFFh.
// - The shunt reading is returned only as the raw direct-format word.
// - A set bit of alert_block_mask keeps the matching status flag off the alert pin.
// - Mask bits 7 to 0 are ready, overflow, reset event, comm, power, current, over and under voltage; reset F0.
// - The comm mask bit acts on the OR of all communication and memory fault bits.
`timescale 1ns/1ps
module measure_control #(
  parameter int CONV_CYC [8] = monitor_pkg::CONV_CYCLES
) (
  // Clock, reset and clock enable.
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // Register commands from the serial link layer.
  input wire logic cmd_strobe,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic setup_write_busy,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic cmd_reject,
  // Converter front end.
  input wire logic [15:0] shunt_sample,
  output logic shunt_conv_active,
  output logic bus_conv_active,
  output logic conv_ready,
  // Status and alert.
  input wire logic [7:0] vendor_status_flags,
  input wire logic [7:0] comm_fault_status,
  output logic alert_active
);
  import monitor_pkg::*;

  logic [SETUP_RW_W-1:0] setup_fields;
  logic [7:0] alert_block_mask;
  logic [15:0] shunt_voltage_reading;
  conv_state_t state;
  conv_state_t next_state;
  logic [TIMER_W-1:0] timer;
  logic [SAMPLE_IDX_W-1:0] sample_idx;
  logic start_req;

  // Command decode.
  wire hit_setup_code = (cmd_code == CMD_ADC_SETUP);
  wire hit_shunt_code = (cmd_code == CMD_SHUNT_READING);
  wire hit_mask_code = (cmd_code == CMD_ALERT_MASK);
  wire known_code = hit_setup_code | hit_shunt_code | hit_mask_code;
  wire setup_wr = cmd_strobe & cmd_write & hit_setup_code;
  wire mask_wr = cmd_strobe & cmd_write & hit_mask_code;
  wire rd_ok = cmd_strobe & ~cmd_write & known_code;
  wire bad_cmd = cmd_strobe & (~known_code | (cmd_write & hit_shunt_code));

  wire [15:0] adc_setup = {SETUP_FIXED_BITS, setup_fields};
  wire [15:0] mask_word = {8'h00, alert_block_mask};
  wire [15:0] read_mux = hit_setup_code ? adc_setup :
                         hit_shunt_code ? shunt_voltage_reading :
                         mask_word;

  // Field selection.
  wire [SEL_W-1:0] avg_sel = setup_fields[AVG_LSB +: SEL_W];
  wire [SEL_W-1:0] bus_sel = setup_fields[BUS_CT_LSB +: SEL_W];
  wire [SEL_W-1:0] shunt_sel = setup_fields[SHUNT_CT_LSB +: SEL_W];
  wire [SEL_W-1:0] mode = setup_fields[MODE_LSB +: SEL_W];
  wire shunt_en = mode[MODE_SHUNT_BIT];
  wire bus_en = mode[MODE_BUS_BIT];
  wire continuous = mode[MODE_CONT_BIT];
  wire powered = shunt_en | bus_en;
  wire [3:0] avg_shift = 4'(AVG_SHIFT[avg_sel]);
  wire [SAMPLE_IDX_W-1:0] last_sample = SAMPLE_IDX_W'((1 << avg_shift) - 1);
  wire [TIMER_W-1:0] bus_cyc = TIMER_W'(CONV_CYC[bus_sel] - 1);
  wire [TIMER_W-1:0] shunt_cyc = TIMER_W'(CONV_CYC[shunt_sel] - 1);

  // Sequencing terms.
  wire halt = setup_write_busy | setup_wr;
  wire phase_end = (state != ST_IDLE) && (timer == '0);
  wire last_phase = (state == ST_BUS) || ((state == ST_SHUNT) && !bus_en);
  wire sample_end = phase_end & last_phase;
  wire seq_end = sample_end && (sample_idx == last_sample);
  wire stop_after = ~continuous;
  wire conv_state_t first_state = shunt_en ? ST_SHUNT : ST_BUS;
  wire leave_idle = (state == ST_IDLE) && (next_state != ST_IDLE);
  wire load_timer = leave_idle | phase_end;
  wire [TIMER_W-1:0] load_value = (next_state == ST_SHUNT) ? shunt_cyc : bus_cyc;
  wire take_shunt = phase_end & (state == ST_SHUNT) & ~halt;
  wire take_last = take_shunt && (sample_idx == last_sample);
  wire avg_clear = halt | (state == ST_IDLE);
  wire [7:0] status_gated = {vendor_status_flags[FLAG_CONV_READY:FLAG_POR],
                             |comm_fault_status,
                             vendor_status_flags[FLAG_OVERPOWER:FLAG_UNDERVOLTAGE]};
  wire next_alert = |(status_gated & ~alert_block_mask);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_req && powered) begin
          next_state = first_state;
        end
      end
      ST_SHUNT: begin
        if (phase_end) begin
          if (bus_en) begin
            next_state = ST_BUS;
          end else if (seq_end && stop_after) begin
            next_state = ST_IDLE;
          end else begin
            next_state = ST_SHUNT;
          end
        end
      end
      ST_BUS: begin
        if (phase_end) begin
          next_state = (seq_end && stop_after) ? ST_IDLE : first_state;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (halt || !powered) begin
      next_state = ST_IDLE;
    end
  end

  // Registers written by the host; reads leave them untouched.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      setup_fields <= ADC_SETUP_RESET[SETUP_RW_W-1:0];
      alert_block_mask <= ALERT_MASK_RESET;
    end else if (clk_en) begin
      if (setup_wr) begin
        setup_fields <= cmd_wdata[SETUP_RW_W-1:0];
      end
      if (mask_wr) begin
        alert_block_mask <= cmd_wdata[7:0];
      end
    end
  end

  // Read answer, one cycle after the strobe.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
      cmd_reject <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= rd_ok;
      cmd_reject <= bad_cmd;
      if (rd_ok) begin
        rd_data <= read_mux;
      end
    end
  end

  // A fresh sequence is requested at reset and by every completed setup write.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      start_req <= 1'b1;
    end else if (clk_en) begin
      if (setup_wr) begin
        start_req <= 1'b1;
      end else if (leave_idle || (!powered && !setup_write_busy)) begin
        start_req <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      timer <= '0;
      sample_idx <= '0;
    end else if (clk_en) begin
      state <= next_state;
      if (load_timer) begin
        timer <= load_value;
      end else if (timer != '0) begin
        timer <= timer - 1'b1;
      end
      if (avg_clear || (sample_end && seq_end)) begin
        sample_idx <= '0;
      end else if (sample_end) begin
        sample_idx <= sample_idx + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      conv_ready <= 1'b0;
      alert_active <= 1'b0;
    end else if (clk_en) begin
      conv_ready <= seq_end & ~halt;
      alert_active <= next_alert;
    end
  end

  assign shunt_conv_active = (state == ST_SHUNT);
  assign bus_conv_active = (state == ST_BUS);

  // Samples arrive already scaled at 2.5 uV per code, two's complement.
  shunt_averager u_averager (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .clear(avg_clear),
    .add(take_shunt),
    .finish(take_last),
    .shift(avg_shift),
    .sample(shunt_sample),
    .result(shunt_voltage_reading)
  );

endmodule : measure_control

/* hw/monitor_pkg.sv */
package monitor_pkg;

  // Command codes of the measurement-control registers.
  localparam logic [7:0] CMD_ADC_SETUP = 8'hD0;
  localparam logic [7:0] CMD_SHUNT_READING = 8'hD1;
  localparam logic [7:0] CMD_ALERT_MASK = 8'hD2;

  // Values after reset.
  localparam logic [15:0] ADC_SETUP_RESET = 16'h4127;
  localparam logic [3:0] SETUP_FIXED_BITS = 4'h4;
  localparam logic [15:0] SHUNT_READING_RESET = 16'h0000;
  localparam logic [7:0] ALERT_MASK_RESET = 8'hF0;

  // Field positions inside adc_setup.
  localparam int AVG_LSB = 9;
  localparam int BUS_CT_LSB = 6;
  localparam int SHUNT_CT_LSB = 3;
  localparam int MODE_LSB = 0;
  localparam int SEL_W = 3;
  localparam int SETUP_RW_W = 12;

  // Bit positions inside the mode field.
  localparam int MODE_SHUNT_BIT = 0;
  localparam int MODE_BUS_BIT = 1;
  localparam int MODE_CONT_BIT = 2;

  // Bit positions inside alert_block_mask and vendor_status_flags.
  localparam int FLAG_CONV_READY = 7;
  localparam int FLAG_OVERFLOW = 6;
  localparam int FLAG_POR = 5;
  localparam int FLAG_COMM = 4;
  localparam int FLAG_OVERPOWER = 3;
  localparam int FLAG_OVERCURRENT = 2;
  localparam int FLAG_OVERVOLTAGE = 1;
  localparam int FLAG_UNDERVOLTAGE = 0;

  // Conversion times in nanoseconds, and the clock period.
  localparam int CLK_PERIOD_NS = 5;
  localparam int CONV_TIME_NS [8] = '{140000, 204000, 332000, 588000,
                                      1100000, 2116000, 4156000, 8244000};
  localparam int CONV_CYCLES [8] = '{
    CONV_TIME_NS[0] / CLK_PERIOD_NS, CONV_TIME_NS[1] / CLK_PERIOD_NS,
    CONV_TIME_NS[2] / CLK_PERIOD_NS, CONV_TIME_NS[3] / CLK_PERIOD_NS,
    CONV_TIME_NS[4] / CLK_PERIOD_NS, CONV_TIME_NS[5] / CLK_PERIOD_NS,
    CONV_TIME_NS[6] / CLK_PERIOD_NS, CONV_TIME_NS[7] / CLK_PERIOD_NS};
  localparam int TIMER_W = 21;

  // Averaging count is one shifted left by this amount: 1, 4, 16 ... 1024.
  localparam int AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
  localparam int SAMPLE_IDX_W = 11;
  localparam int ACC_W = 26;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHUNT = 2'b01,
    ST_BUS = 2'b10
  } conv_state_t;

endpackage : monitor_pkg

/* hw/shunt_averager.sv */
`timescale 1ns/1ps
module shunt_averager (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // Sample stream.
  input wire logic clear,
  input wire logic add,
  input wire logic finish,
  input wire logic [3:0] shift,
  input wire logic signed [15:0] sample,
  // Result.
  output logic [15:0] result
);
  import monitor_pkg::*;

  logic signed [ACC_W-1:0] sum;
  wire signed [ACC_W-1:0] total = sum + ACC_W'(sample);
  wire signed [ACC_W-1:0] mean = total >>> shift;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sum <= '0;
      result <= SHUNT_READING_RESET;
    end else if (clk_en) begin
      if (clear) begin
        sum <= '0;
      end else if (add && finish) begin
        sum <= '0;
        result <= mean[15:0];
      end else if (add) begin
        sum <= total;
      end
    end
  end

endmodule : shunt_averager
